// >>> hw/tcpu_pkg.sv
// shared constants for the teaching cpu decode and execute block
package tcpu_pkg;

    // ****************************************************************
    // instruction fields and opcodes
    // ****************************************************************
    localparam int OPC_HI  = 15;
    localparam int OPC_LO  = 12;
    localparam int DST_HI  = 11;
    localparam int DST_LO  = 10;
    localparam int SRA_HI  = 9;
    localparam int SRA_LO  = 8;
    localparam int SRB_HI  = 7;
    localparam int SRB_LO  = 6;
    localparam int AUX_HI  = 5;
    localparam int BYTE_HI = 7;

    localparam logic [3:0] OP_BEQ  = 4'h0;
    localparam logic [3:0] OP_BNE  = 4'h1;
    localparam logic [3:0] OP_BLT  = 4'h2;
    localparam logic [3:0] OP_BGE  = 4'h3;
    localparam logic [3:0] OP_CALL = 4'h4;
    localparam logic [3:0] OP_STOP = 4'h5;
    localparam logic [3:0] OP_ARI  = 4'h6;
    localparam logic [3:0] OP_SFT  = 4'h7;
    localparam logic [3:0] OP_ADDC = 4'h8;
    localparam logic [3:0] OP_ANDC = 4'h9;
    localparam logic [3:0] OP_ORC  = 4'hA;
    localparam logic [3:0] OP_XORC = 4'hB;
    localparam logic [3:0] OP_NONE = 4'hC;
    localparam logic [3:0] OP_LDHI = 4'hD;
    localparam logic [3:0] OP_STO  = 4'hE;
    localparam logic [3:0] OP_LOA  = 4'hF;

    // ****************************************************************
    // alu operation codes (same as the three-register aux field)
    // ****************************************************************
    localparam logic [3:0] ALU_ADD = 4'h0;
    localparam logic [3:0] ALU_SUB = 4'h1;
    localparam logic [3:0] ALU_AND = 4'h4;
    localparam logic [3:0] ALU_OR  = 4'h5;
    localparam logic [3:0] ALU_XOR = 4'h6;
    localparam logic [3:0] ALU_SLL = 4'h8;
    localparam logic [3:0] ALU_SLR = 4'h9;
    localparam logic [3:0] ALU_SAL = 4'hA;
    localparam logic [3:0] ALU_SAR = 4'hB;
    localparam logic [1:0] SFT_BASE = 2'h2;

    // ****************************************************************
    // halt status codes
    // ****************************************************************
    localparam logic [5:0] HALT_OK     = 6'h00;
    localparam logic [5:0] HALT_UNIMPL = 6'h01;
    localparam logic [5:0] HALT_FORMAT = 6'h02;
    localparam logic [5:0] HALT_ODDPC  = 6'h03;
    localparam logic [5:0] HALT_BOUNDS = 6'h04;

    // ****************************************************************
    // register port map and reset values
    // ****************************************************************
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_STATUS = 4'h1;
    localparam logic [3:0]  REG_PC     = 4'h2;
    localparam logic [3:0]  REG_INSTR  = 4'h3;
    localparam logic [1:0]  REG_GPR_HI = 2'h1;
    localparam int          CTRL_START = 0;
    localparam int          ST_RUN     = 0;
    localparam int          ST_HALT    = 1;
    localparam int          ST_CODE_LO = 8;
    localparam logic [15:0] PC_RST     = 16'h0000;
    localparam logic [15:0] WORD_RST   = 16'h0000;
    localparam int          MEM_BYTES_DEF = 1024;

endpackage

// >>> hw/tcpu_alu_if.sv
// operand and result bundle between the core and its alu
`timescale 1ns/1ps
interface tcpu_alu_if;
    logic [15:0] a;
    logic [15:0] b;
    logic [3:0]  op;
    logic [15:0] result;
    logic        legal;

    modport core (output a, output b, output op, input result, input legal);
    modport alu  (input a, input b, input op, output result, output legal);
endinterface

// >>> hw/tcpu_alu.sv
// combinational alu: arithmetic, logic and signed-distance shifts
`timescale 1ns/1ps
module tcpu_alu (
    // operands and result
    tcpu_alu_if.alu bus
);
    import tcpu_pkg::*;

    logic        neg_dist;
    logic [15:0] mag;
    logic        go_left;
    logic        arith;
    logic [15:0] fill;
    logic [15:0] sh_res;

    // ****************************************************************
    // shifter
    // ****************************************************************
    // a negative distance flips the direction; beyond 15 only fill remains
    assign neg_dist = bus.b[15];
    assign mag      = neg_dist ? 16'(-bus.b) : bus.b;
    assign go_left  = ~bus.op[0] ^ neg_dist;
    assign arith    = bus.op[1];
    // arithmetic left fills with zeros like logical left
    assign fill     = (arith && !go_left) ? {16{bus.a[15]}} : 16'h0000;
    assign sh_res   = (mag > 16'h000F) ? fill :
                      go_left ? (bus.a << mag[3:0]) :
                      arith   ? 16'($signed(bus.a) >>> mag[3:0]) :
                                (bus.a >> mag[3:0]);

    // ****************************************************************
    // operation select
    // ****************************************************************
    // undefined codes report illegal so the core can halt on them
    always_comb begin
        bus.legal = 1'b1;
        case (bus.op)
            ALU_ADD: bus.result = 16'(bus.a + bus.b);
            ALU_SUB: bus.result = 16'(bus.a - bus.b);
            ALU_AND: bus.result = bus.a & bus.b;
            ALU_OR:  bus.result = bus.a | bus.b;
            ALU_XOR: bus.result = bus.a ^ bus.b;
            ALU_SLL, ALU_SLR, ALU_SAL, ALU_SAR: bus.result = sh_res;
            default: begin
                bus.result = 16'h0000;
                bus.legal  = 1'b0;
            end
        endcase
    end

endmodule // tcpu_alu

// >>> hw/tcpu_core.sv
// decode and execute core of the small 16-bit teaching processor
`timescale 1ns/1ps

// Function
// - opcode is top four instruction bits
// - two-bit fields pick one of four registers
// - opcodes 0-3 compare and branch relatively
// - counter already points past current instruction
// - call swaps counter and register using old values
// - opcode 5 halts with six-bit status
// - automatic halts with codes one to four
// - opcode 6 three-register alu by aux
// - negative distance reverses, large distance fills
// - opcode 7 immediate shift kind by aux
// - immediate distance is low aux plus one
// - opcodes 8-b byte-constant add, and, or, xor
// - opcode c halts as illegal instruction
// - opcode d replaces only upper byte
// - opcodes e-f store and load memory
module tcpu_core #(
    parameter int MEM_BYTES = tcpu_pkg::MEM_BYTES_DEF
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // word memory port, byte address, read data one cycle after mem_rd
    output logic      [15:0] mem_addr,
    output logic      [15:0] mem_wdata,
    output logic             mem_wr,
    output logic             mem_rd,
    input  wire logic [15:0] mem_rdata,
    // status
    output logic             running,
    output logic             halted,
    output logic      [5:0]  halt_code
);
    import tcpu_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_FETCH  = 3'b001,
        S_ISSUE  = 3'b010,
        S_IWAIT  = 3'b011,
        S_EXEC   = 3'b100,
        S_LISSUE = 3'b101,
        S_LWAIT  = 3'b110
    } tcpu_state_t;

    localparam logic [16:0] MEM_TOP = 17'(MEM_BYTES);

    tcpu_state_t state_reg;
    logic [15:0] pc_reg;
    logic [15:0] ir_reg;
    logic [15:0] gpr_reg [4];
    logic [15:0] reg_rdata_reg;
    logic [15:0] mem_addr_reg;
    logic [15:0] mem_wdata_reg;
    logic        mem_wr_reg;
    logic        mem_rd_reg;
    logic        halted_reg;
    logic [5:0]  halt_code_reg;
    logic        running_reg;

    tcpu_alu_if alu_bus ();

    // ****************************************************************
    // field decode
    // ****************************************************************
    logic [3:0]  opc;
    logic [1:0]  dst;
    logic [1:0]  sra;
    logic [1:0]  srb;
    logic [5:0]  aux;
    logic [15:0] sbyte;
    logic [15:0] vd;
    logic [15:0] va;
    logic [15:0] vb;
    assign opc   = ir_reg[OPC_HI:OPC_LO];
    assign dst   = ir_reg[DST_HI:DST_LO];
    assign sra   = ir_reg[SRA_HI:SRA_LO];
    assign srb   = ir_reg[SRB_HI:SRB_LO];
    assign aux   = ir_reg[AUX_HI:0];
    assign sbyte = {{8{ir_reg[BYTE_HI]}}, ir_reg[BYTE_HI:0]};
    // register zero is never written, so it always reads zero
    assign vd    = gpr_reg[dst];
    assign va    = gpr_reg[sra];
    assign vb    = gpr_reg[srb];

    // ****************************************************************
    // alu operand routing
    // ****************************************************************
    logic [1:0] cop;
    assign cop = opc[1:0];
    assign alu_bus.a  = va;
    assign alu_bus.b  = (opc == OP_ARI) ? vb :
                        (opc == OP_SFT) ? 16'({12'h000, aux[3:0]} + 16'h0001) :
                        sbyte;
    assign alu_bus.op = (opc == OP_ARI) ? aux[3:0] :
                        (opc == OP_SFT) ? {SFT_BASE, aux[5:4]} :
                        (cop == 2'h0) ? ALU_ADD :
                        (cop == 2'h1) ? ALU_AND :
                        (cop == 2'h2) ? ALU_OR : ALU_XOR;

    tcpu_alu u_alu (
        .bus (alu_bus.alu)
    );

    // ****************************************************************
    // branch, address and fault decode
    // ****************************************************************
    logic        take;
    logic [15:0] ea;
    logic        ea_oob;
    logic        pc_oob;
    logic        fmt_bad;
    logic        unimpl;
    assign take    = (opc == OP_BEQ) ? (vd == va) :
                     (opc == OP_BNE) ? (vd != va) :
                     (opc == OP_BLT) ? ($signed(vd) <  $signed(va)) :
                                       ($signed(vd) >= $signed(va));
    assign ea      = 16'(va + sbyte);
    // both bytes of the word must lie inside memory
    assign ea_oob  = (17'(ea) + 17'h00001) >= MEM_TOP;
    assign pc_oob  = (17'(pc_reg) + 17'h00001) >= MEM_TOP;
    // the device still checks the zero fields software must keep
    assign fmt_bad = ((opc == OP_CALL) && (ir_reg[BYTE_HI:0] != 8'h00)) ||
                     ((opc == OP_STOP) && (ir_reg[DST_HI:SRB_LO] != 6'h00)) ||
                     ((opc == OP_SFT)  && (srb != 2'h0)) ||
                     ((opc == OP_ARI)  && (aux[5:4] != 2'h0)) ||
                     ((opc == OP_LDHI) && (sra != 2'h0));
    assign unimpl  = (opc == OP_NONE) ||
                     ((opc == OP_ARI) && !alu_bus.legal);

    // ****************************************************************
    // register write-back
    // ****************************************************************
    logic        ex_ok;
    logic        wb_en;
    logic [15:0] wb_data;
    assign ex_ok   = (state_reg == S_EXEC) && !fmt_bad && !unimpl;
    assign wb_en   = (ex_ok && (opc == OP_CALL || opc == OP_ARI || opc == OP_SFT ||
                                (opc >= OP_ADDC && opc <= OP_XORC) || opc == OP_LDHI)) ||
                     (state_reg == S_LWAIT);
    assign wb_data = (state_reg == S_LWAIT) ? mem_rdata :
                     (opc == OP_CALL) ? pc_reg :
                     (opc == OP_LDHI) ? {ir_reg[BYTE_HI:0], vd[7:0]} :
                     alu_bus.result;

    // ****************************************************************
    // software register port decode
    // ****************************************************************
    logic stopped;
    logic hit_gpr;
    logic wr_start;
    assign stopped  = (state_reg == S_IDLE);
    assign hit_gpr  = (reg_addr[3:2] == REG_GPR_HI);
    assign wr_start = reg_wr && stopped && (reg_addr == REG_CTRL) && reg_wdata[CTRL_START];

    logic [15:0] rd_mux;
    assign rd_mux = (reg_addr == REG_CTRL)   ? WORD_RST :
                    (reg_addr == REG_STATUS) ? {2'h0, halt_code_reg, 6'h00, halted_reg, !stopped} :
                    (reg_addr == REG_PC)     ? pc_reg :
                    (reg_addr == REG_INSTR)  ? ir_reg :
                    hit_gpr                  ? gpr_reg[reg_addr[1:0]] :
                                               WORD_RST;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_reg <= WORD_RST;
        end else begin
            reg_rdata_reg <= reg_rd ? rd_mux : WORD_RST;
        end
    end

    // general registers: core write-back, or software while stopped
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 4; i++) begin
                gpr_reg[i] <= WORD_RST;
            end
        end else if (wb_en && ((state_reg == S_LWAIT ? ir_reg[DST_HI:DST_LO] : dst) != 2'h0)) begin
            gpr_reg[dst] <= wb_data;
        end else if (reg_wr && stopped && hit_gpr && (reg_addr[1:0] != 2'h0)) begin
            gpr_reg[reg_addr[1:0]] <= reg_wdata;
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    // one memory access at a time; strobes are single-cycle pulses
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg     <= S_IDLE;
            pc_reg        <= PC_RST;
            ir_reg        <= WORD_RST;
            mem_addr_reg  <= WORD_RST;
            mem_wdata_reg <= WORD_RST;
            mem_wr_reg    <= 1'b0;
            mem_rd_reg    <= 1'b0;
            halted_reg    <= 1'b0;
            halt_code_reg <= HALT_OK;
        end else begin
            mem_wr_reg <= 1'b0;
            mem_rd_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (reg_wr && reg_addr == REG_PC) begin
                        pc_reg <= reg_wdata;
                    end
                    if (wr_start) begin
                        halted_reg <= 1'b0;
                        state_reg  <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (pc_reg[0]) begin
                        halted_reg    <= 1'b1;
                        halt_code_reg <= HALT_ODDPC;
                        state_reg     <= S_IDLE;
                    end else if (pc_oob) begin
                        halted_reg    <= 1'b1;
                        halt_code_reg <= HALT_BOUNDS;
                        state_reg     <= S_IDLE;
                    end else begin
                        mem_addr_reg <= pc_reg;
                        mem_rd_reg   <= 1'b1;
                        state_reg    <= S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    state_reg <= S_IWAIT;
                end
                S_IWAIT: begin
                    ir_reg    <= mem_rdata;
                    pc_reg    <= 16'(pc_reg + 16'h0002);
                    state_reg <= S_EXEC;
                end
                S_EXEC: begin
                    state_reg <= S_FETCH;
                    if (unimpl) begin
                        halted_reg    <= 1'b1;
                        halt_code_reg <= HALT_UNIMPL;
                        state_reg     <= S_IDLE;
                    end else if (fmt_bad) begin
                        halted_reg    <= 1'b1;
                        halt_code_reg <= HALT_FORMAT;
                        state_reg     <= S_IDLE;
                    end else if (opc <= OP_BGE) begin
                        // odd targets are caught at the next fetch
                        if (take) begin
                            pc_reg <= 16'(pc_reg + sbyte);
                        end
                    end else if (opc == OP_CALL) begin
                        pc_reg <= va;
                    end else if (opc == OP_STOP) begin
                        halted_reg    <= 1'b1;
                        halt_code_reg <= aux;
                        state_reg     <= S_IDLE;
                    end else if (opc == OP_STO || opc == OP_LOA) begin
                        if (ea_oob) begin
                            halted_reg    <= 1'b1;
                            halt_code_reg <= HALT_BOUNDS;
                            state_reg     <= S_IDLE;
                        end else begin
                            mem_addr_reg  <= ea;
                            mem_wdata_reg <= vd;
                            mem_wr_reg    <= (opc == OP_STO);
                            mem_rd_reg    <= (opc == OP_LOA);
                            state_reg     <= (opc == OP_LOA) ? S_LISSUE : S_FETCH;
                        end
                    end
                end
                S_LISSUE: begin
                    state_reg <= S_LWAIT;
                end
                S_LWAIT: begin
                    state_reg <= S_FETCH;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // run flag
    // ****************************************************************
    // a flop rather than a state decode, so the pin cannot glitch
    logic to_idle;
    assign to_idle = ((state_reg == S_FETCH) && (pc_reg[0] || pc_oob)) ||
                     ((state_reg == S_EXEC) && (unimpl || fmt_bad || (opc == OP_STOP) ||
                                               (((opc == OP_STO) || (opc == OP_LOA)) && ea_oob)));
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            running_reg <= 1'b0;
        end else begin
            running_reg <= stopped ? wr_start : !to_idle;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata = reg_rdata_reg;
    assign mem_addr  = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign mem_wr    = mem_wr_reg;
    assign mem_rd    = mem_rd_reg;
    assign running   = running_reg;
    assign halted    = halted_reg;
    assign halt_code = halt_code_reg;

endmodule // tcpu_core

// >>> sim/tcpu_mem.sv
// word-wide byte memory standing on the far side of the core
`timescale 1ns/1ps
module tcpu_mem #(
    parameter int MEM_BYTES = 1024
) (
    // memory port
    input  wire logic        clock,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic        mem_wr,
    input  wire logic        mem_rd,
    output logic      [15:0] mem_rdata
);
    logic [7:0] mem [MEM_BYTES];

    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        mem_rdata = 16'h0000;
    end

    // low byte at addr, high byte at addr+1; idle data toggles so stale reads show
    always @(posedge clock) begin
        if (mem_wr) begin
            mem[mem_addr]      <= mem_wdata[7:0];
            mem[mem_addr + 1]  <= mem_wdata[15:8];
        end
        if (mem_rd) mem_rdata <= {mem[mem_addr + 1], mem[mem_addr]};
        else mem_rdata <= ~mem_rdata;
    end
endmodule // tcpu_mem

// >>> sim/tcpu_core_chk.sv
// port-level assertions for the decode and execute core
`timescale 1ns/1ps
module tcpu_core_chk #(
    parameter int MEM_BYTES = 1024
) (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_b,
    // register port
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // memory port
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic        mem_wr,
    input wire logic        mem_rd,
    input wire logic [15:0] mem_rdata,
    // status
    input wire logic        running,
    input wire logic        halted,
    input wire logic [5:0]  halt_code
);
    import tcpu_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // ****************************************
    // sequences and assertions
    // ****************************************
    sequence start_req_s;
        reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START] && !running;
    endsequence
    sequence run_clean_s;
        running && !halted;
    endsequence

    start_runs_a: assert property (start_req_s |=> run_clean_s) else $error("start ignored");
    halt_stops_a: assert property ($rose(halted) |-> ##[0:1] !running) else $error("runs after halt");
    code_holds_a: assert property (halted && $past(halted) |-> $stable(halt_code)) else $error("code moved");
    in_bounds_a: assert property ((mem_rd || mem_wr) |-> 32'(mem_addr) + 1 < MEM_BYTES)
        else $error("access out of range");
    one_access_a: assert property (mem_rd |=> !mem_rd && !mem_wr) else $error("access overlap");
    store_pulse_a: assert property (mem_wr |=> !mem_wr) else $error("store strobe long");
    idle_quiet_a: assert property (!running && !$past(running) |-> !(mem_rd || mem_wr))
        else $error("access while idle");
    status_read_a: assert property (reg_rd && reg_addr == REG_STATUS |=>
        reg_rdata[13:8] == $past(halt_code) && reg_rdata[ST_HALT] == $past(halted))
        else $error("status read wrong");
    zero_reg_a: assert property (reg_rd && reg_addr == 4'h4 |=> reg_rdata == 16'h0000)
        else $error("r0 not zero");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("read data not cleared");
endmodule // tcpu_core_chk

bind tcpu_core tcpu_core_chk #(.MEM_BYTES(MEM_BYTES)) i_chk (.clock(clock), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .running(running), .halted(halted), .halt_code(halt_code));

// >>> sim/tcpu_core_tb.sv
// self-checking bench: one instruction per run, then register and status readback
`timescale 1ns/1ps
module tcpu_core_tb;
    import tcpu_pkg::*;
    logic        clock, rst_b, reg_wr, reg_rd, mem_wr, mem_rd, running, halted;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, ins, b, e, got;
    logic [5:0]  halt_code, c;
    int          n_fail = 0, n_tests = 0, k;
    // instruction, r2 value, expected r3, expected halt code; r1 is 8421
    localparam logic [53:0] TV [44] = '{
        {16'h6D80, 16'h0003, 16'h8424, 6'h11}, {16'h6D81, 16'h0003, 16'h841E, 6'h11},
        {16'h6D84, 16'h0003, 16'h0001, 6'h11}, {16'h6D85, 16'h0003, 16'h8423, 6'h11},
        {16'h6D86, 16'h0003, 16'h8422, 6'h11}, {16'h6D88, 16'h0003, 16'h2108, 6'h11},
        {16'h6D89, 16'h0003, 16'h1084, 6'h11}, {16'h6D8A, 16'h0003, 16'h2108, 6'h11},
        {16'h6D8B, 16'h0003, 16'hF084, 6'h11}, {16'h6D88, 16'hFFFD, 16'h1084, 6'h11},
        {16'h6D89, 16'h0010, 16'h0000, 6'h11}, {16'h6D8B, 16'h0014, 16'hFFFF, 6'h11},
        {16'h6D8B, 16'hFFFE, 16'h1084, 6'h11}, {16'h7D00, 16'h0000, 16'h0842, 6'h11},
        {16'h7D13, 16'h0000, 16'h0842, 6'h11}, {16'h7D21, 16'h0000, 16'h1084, 6'h11},
        {16'h7D3F, 16'h0000, 16'hFFFF, 6'h11}, {16'h8DFF, 16'h0000, 16'h8420, 6'h11},
        {16'h9D0F, 16'h0000, 16'h0001, 6'h11}, {16'hAD80, 16'h0000, 16'hFFA1, 6'h11},
        {16'hBDFF, 16'h0000, 16'h7BDE, 6'h11}, {16'hDC5A, 16'h0000, 16'h5AC3, 6'h11},
        {16'h6C40, 16'h0000, 16'h8421, 6'h11}, {16'h6C41, 16'h0000, 16'h7BDF, 6'h11},
        {16'hE602, 16'h0100, 16'h00C3, 6'h11}, {16'hFEFE, 16'h0104, 16'h8421, 6'h11},
        {16'h0602, 16'h8421, 16'h00C3, 6'h00}, {16'h1602, 16'h8421, 16'h00C3, 6'h11},
        {16'h2602, 16'h0003, 16'h00C3, 6'h00}, {16'h3602, 16'h0003, 16'h00C3, 6'h11},
        {16'h3602, 16'h8421, 16'h00C3, 6'h00}, {16'h4E00, 16'h0004, 16'h0002, 6'h00},
        {16'h4F00, 16'h0000, 16'h0002, 6'h03}, {16'hC000, 16'h0000, 16'h00C3, 6'h01},
        {16'h6D82, 16'h0003, 16'h00C3, 6'h01}, {16'h4E01, 16'h0004, 16'h00C3, 6'h02},
        {16'h7D40, 16'h0000, 16'h00C3, 6'h02}, {16'h5100, 16'h0000, 16'h00C3, 6'h02},
        {16'hFE00, 16'h03FF, 16'h00C3, 6'h04}, {16'hFE00, 16'h03FE, 16'h0000, 6'h11},
        {16'h4E00, 16'h0400, 16'h0002, 6'h04}, {16'h6D90, 16'h0003, 16'h00C3, 6'h02},
        {16'hDD5A, 16'h0000, 16'h00C3, 6'h02},
        {16'h503F, 16'h0000, 16'h00C3, 6'h3F}};

    tcpu_core #(.MEM_BYTES(1024)) i_dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .running(running),
        .halted(halted), .halt_code(halt_code));
    tcpu_mem #(.MEM_BYTES(1024)) i_mem (.clock(clock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));

    // ****************************************
    // access tasks
    // ****************************************
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] x);
        n_tests++;
        if (g !== x) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // program words poked straight into the model while the core is idle
    task put(input int a, input logic [15:0] w);
        i_mem.mem[a] = w[7:0];
        i_mem.mem[a + 1] = w[15:8];
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        conclude();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_b = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        rd(REG_PC, got); chk(got, PC_RST);
        rd(REG_STATUS, got); chk(got, 16'h0000);
        rd(4'h8, got); chk(got, 16'h0000);
        wr(4'h4, 16'hFFFF);
        rd(4'h4, got); chk(got, 16'h0000);
        put(2, 16'h5011);
        put(4, 16'h5000);
        foreach (TV[i]) begin
            {ins, b, e, c} = TV[i];
            put(0, ins);
            wr(4'h5, 16'h8421);
            wr(4'h6, b);
            wr(4'h7, 16'h00C3);
            wr(REG_PC, 16'h0000);
            wr(REG_CTRL, 16'h0001);
            repeat (2) @(posedge clock);
            for (k = 0; k < 100 && halted !== 1'b1; k++) @(posedge clock);
            rd(4'h7, got); chk(got, e);
            rd(REG_STATUS, got); chk(got, {2'b00, c, 8'h02});
        end
        chk({i_mem.mem[16'h103], i_mem.mem[16'h102]}, 16'h8421);
        rd(REG_INSTR, got); chk(got, 16'h503F);
        conclude();
    end
endmodule // tcpu_core_tb
